// *** verilog/irq_params.svh ***
// Purpose: register offsets, field positions, reset values and fixed codes
// Assumes: 8-bit wishbone byte address, 32-bit data
// Notes: included by the interrupt acceptance block and its source slot leaf
`ifndef IRQ_PARAMS_SVH
`define IRQ_PARAMS_SVH

// ==========================================================
// register offsets
`define IRQ_FLG_OFS 8'h00
`define IRQ_IPL_OFS 8'h04
`define IRQ_STAT_OFS 8'h08
`define IRQ_CTRL_BASE 8'h40

// ==========================================================
// field positions
`define IRQ_CTRL_LVL_MSB 2
`define IRQ_CTRL_REQ_BIT 3
`define IRQ_FLG_I_BIT 0
`define IRQ_FLG_D_BIT 1
`define IRQ_FLG_U_BIT 2

// ==========================================================
// reset values and fixed codes
`define IRQ_FLG_RST 8'h00
`define IRQ_LVL_RST 3'h0
`define IRQ_IPL_RST 3'h0
`define IRQ_IPL_WDT 3'h7
`define IRQ_IPL_MAX 3'h7
`define IRQ_INFO_ADDR 20'h00000
`define IRQ_SW_KEEPU_LO 6'h20
`define IRQ_SW_KEEPU_HI 6'h3f

`endif

// *** verilog/irq_pkg.sv ***
// Purpose: types shared by the interrupt acceptance block
// Assumes: classic wishbone with 8-bit byte address
// Notes: constants live in irq_params.svh
package irq_pkg;

  // ==========================================================
  // sequence states and accepted kinds
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_INFO,
    ST_SAVE,
    ST_CLEAR,
    ST_PUSH_FLG,
    ST_PUSH_PC,
    ST_LOAD_IPL
  } seq_state_type;

  typedef enum logic [1:0] {
    KIND_MASK,
    KIND_WDT,
    KIND_SW
  } irq_kind_type;

  // ==========================================================
  // bus and cpu carriers
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_type;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_type;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } stack_push_type;

endpackage : irq_pkg

// *** verilog/irq_source_slot.sv ***
// Purpose: one maskable source: priority level and pending request bit
// Assumes: hwSet is a one-cycle pulse on clk
// Notes: hardware set beats any clear in the same cycle
`timescale 1ns/1ps
`include "irq_params.svh"

module irq_source_slot
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // events
  input wire logic hwSet,
  input wire logic ackClr,
  input wire logic wrEn,
  input wire logic [3:0] wrData,
  // compare and state
  input wire logic [2:0] processor_priority_level,
  output logic [2:0] level,
  output logic request,
  output logic eligible
);

  logic req_r;
  logic req_nxt;
  logic [2:0] lvl_r;

  // ==========================================================
  // pending bit: set wins, software may only clear
  assign req_nxt = hwSet ? 1'b1 :
                   (ackClr || (wrEn && !wrData[`IRQ_CTRL_REQ_BIT])) ? 1'b0 :
                   req_r;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      req_r <= 1'b0;
      lvl_r <= `IRQ_LVL_RST;
    end
    else
    begin
      req_r <= req_nxt;
      if (wrEn)
        lvl_r <= wrData[`IRQ_CTRL_LVL_MSB:0];
    end
  end

  assign level = lvl_r;
  assign request = req_r;
  // level 0 never exceeds any ipl, so it disables the source
  assign eligible = req_r && (lvl_r > processor_priority_level);

endmodule : irq_source_slot

// *** verilog/irq_priority_judge.sv ***
// Purpose: pick the eligible source with the highest level
// Assumes: lower index means higher fixed hardware priority
// Notes: purely combinational
`timescale 1ns/1ps

module irq_priority_judge #(
  parameter int NUM_SRC = 8,
  parameter int IDX_W = 3
)
(
  // candidates
  input wire logic [NUM_SRC-1:0] eligible,
  input wire logic [2:0] level [NUM_SRC],
  // winner
  output logic selValid,
  output logic [IDX_W-1:0] selIdx,
  output logic [2:0] selLevel
);

  // ==========================================================
  // scan from the lowest hardware priority so ties go to lower index
  always_comb
  begin
    selValid = 1'b0;
    selIdx = '0;
    selLevel = 3'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (eligible[i] && (!selValid || level[i] >= selLevel))
      begin
        selValid = 1'b1;
        selIdx = IDX_W'(i);
        selLevel = level[i];
      end
    end
  end

endmodule : irq_priority_judge

// *** verilog/maskable_interrupt_acceptance.sv ***
// Purpose: maskable interrupt acceptance and interrupt sequence control
// Assumes: cpu strobes arrive on clk; wishbone classic slave, one wait state
// Notes: the flag temp register is not reachable from the bus
`timescale 1ns/1ps
`include "irq_params.svh"

module maskable_interrupt_acceptance #(
  parameter int NUM_SRC = 8,
  parameter logic [5:0] VEC_BASE = 6'h08,
  parameter logic [5:0] WDT_VEC = 6'h3e
)
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register bus
  input wire irq_pkg::wb_req_type wbReq,
  output irq_pkg::wb_rsp_type wbRsp,
  // peripheral and watchdog events
  input wire logic [NUM_SRC-1:0] srcPulse,
  input wire logic wdtReq,
  // cpu execution state
  input wire logic instrDone,
  input wire logic stringActive,
  input wire logic swIntReq,
  input wire logic [5:0] swIntNum,
  input wire logic [19:0] pcIn,
  // cpu sequence outputs
  output logic seqBusy,
  output logic suspendReq,
  output logic infoRead,
  output logic [19:0] infoAddr,
  output irq_pkg::stack_push_type stackPush,
  output logic vectorValid,
  output logic [5:0] vectorNum,
  output logic [2:0] procPriorityLevel
);
  import irq_pkg::*;

  localparam int IW = (NUM_SRC > 1) ? $clog2(NUM_SRC) : 1;

  // ==========================================================
  // state
  seq_state_type state_r;
  seq_state_type state_nxt;
  irq_kind_type kind_r;
  irq_kind_type kind_nxt;
  logic [7:0] flg_r;
  logic [7:0] tmpFlg_r;
  logic [2:0] ipl_r;
  logic [IW-1:0] accIdx_r;
  logic [2:0] accLvl_r;
  logic [5:0] accNum_r;
  logic [19:0] pcSave_r;
  logic wdtPend_r;
  logic ack_r;
  logic [31:0] rdData_r;
  logic busy_r;
  logic suspend_r;
  logic info_r;
  logic pushValid_r;
  logic [15:0] pushData_r;
  logic vecValid_r;
  logic [5:0] vecNum_r;

  // ==========================================================
  // bus decode
  wire logic busReq = wbReq.cyc && wbReq.stb && !ack_r;
  // write lands on the ack edge, while the master still holds its request
  wire logic busWr = wbReq.cyc && wbReq.stb && ack_r && wbReq.we && wbReq.sel[0];
  wire logic hitFlg = wbReq.adr == `IRQ_FLG_OFS;
  wire logic hitIpl = wbReq.adr == `IRQ_IPL_OFS;
  wire logic hitStat = wbReq.adr == `IRQ_STAT_OFS;
  wire logic [7:0] ctrlOff = wbReq.adr - `IRQ_CTRL_BASE;
  wire logic hitCtrl = (wbReq.adr >= `IRQ_CTRL_BASE) && (ctrlOff[1:0] == 2'h0)
                       && (ctrlOff[7:2] < 6'(NUM_SRC));
  wire logic [IW-1:0] ctrlIdx = ctrlOff[IW+1:2];

  // ==========================================================
  // source slots
  logic [NUM_SRC-1:0] reqVec;
  logic [NUM_SRC-1:0] eligVec;
  logic [2:0] lvlVec [NUM_SRC];
  wire logic clrPulse = (state_r == ST_INFO) && (kind_r == KIND_MASK);

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++)
    begin : slot
      irq_source_slot u_slot (
        .clk(clk),
        .resetn(resetn),
        .hwSet(srcPulse[g]),
        .ackClr(clrPulse && (accIdx_r == IW'(g))),
        .wrEn(busWr && hitCtrl && (ctrlIdx == IW'(g))),
        .wrData(wbReq.dat[3:0]),
        .processor_priority_level(ipl_r),
        .level(lvlVec[g]),
        .request(reqVec[g]),
        .eligible(eligVec[g])
      );
    end
  endgenerate

  logic selValid;
  logic [IW-1:0] selIdx;
  logic [2:0] selLvl;

  irq_priority_judge #(
    .NUM_SRC(NUM_SRC),
    .IDX_W(IW)
  ) u_judge (
    .eligible(eligVec),
    .level(lvlVec),
    .selValid(selValid),
    .selIdx(selIdx),
    .selLevel(selLvl)
  );

  // ==========================================================
  // acceptance
  wire logic boundary = instrDone || stringActive;
  wire logic takeWdt = (state_r == ST_IDLE) && boundary && wdtPend_r;
  wire logic takeSw = (state_r == ST_IDLE) && instrDone && swIntReq && !takeWdt;
  wire logic takeMask = (state_r == ST_IDLE) && boundary && !takeWdt && !takeSw
                        && flg_r[`IRQ_FLG_I_BIT] && selValid;
  wire logic take = takeWdt || takeSw || takeMask;
  wire logic keepU = (kind_r == KIND_SW) && (accNum_r >= `IRQ_SW_KEEPU_LO)
                     && (accNum_r <= `IRQ_SW_KEEPU_HI);

  assign kind_nxt = takeWdt ? KIND_WDT : takeSw ? KIND_SW : KIND_MASK;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (take)
          state_nxt = ST_INFO;
      ST_INFO:
        state_nxt = ST_SAVE;
      ST_SAVE:
        state_nxt = ST_CLEAR;
      ST_CLEAR:
        state_nxt = ST_PUSH_FLG;
      ST_PUSH_FLG:
        state_nxt = ST_PUSH_PC;
      ST_PUSH_PC:
        state_nxt = ST_LOAD_IPL;
      ST_LOAD_IPL:
        state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_r <= ST_IDLE;
      kind_r <= KIND_MASK;
      accIdx_r <= '0;
      accLvl_r <= 3'h0;
      accNum_r <= 6'h00;
      pcSave_r <= 20'h00000;
    end
    else
    begin
      state_r <= state_nxt;
      if (take)
      begin
        kind_r <= kind_nxt;
        accIdx_r <= selIdx;
        accLvl_r <= takeWdt ? `IRQ_IPL_WDT : selLvl;
        accNum_r <= takeWdt ? WDT_VEC : takeSw ? swIntNum : VEC_BASE + 6'(selIdx);
        pcSave_r <= pcIn;
      end
    end
  end

  // watchdog event held until taken; a new event beats the clear
  always_ff @(posedge clk)
  begin
    if (!resetn)
      wdtPend_r <= 1'b0;
    else
      wdtPend_r <= wdtReq || (wdtPend_r && !takeWdt);
  end

  // ==========================================================
  // flags, temporary copy and priority level
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      flg_r <= `IRQ_FLG_RST;
      tmpFlg_r <= `IRQ_FLG_RST;
      ipl_r <= `IRQ_IPL_RST;
    end
    else
    begin
      if (state_r == ST_SAVE)
        tmpFlg_r <= flg_r;
      if (state_r == ST_CLEAR)
      begin
        flg_r[`IRQ_FLG_I_BIT] <= 1'b0;
        flg_r[`IRQ_FLG_D_BIT] <= 1'b0;
        if (!keepU)
          flg_r[`IRQ_FLG_U_BIT] <= 1'b0;
      end
      else if (busWr && hitFlg)
        flg_r <= wbReq.dat[7:0];
      if (state_r == ST_LOAD_IPL && kind_r != KIND_SW)
        ipl_r <= accLvl_r;
      else if (busWr && hitIpl)
        ipl_r <= wbReq.dat[2:0];
    end
  end

  // ==========================================================
  // cpu-facing outputs, aligned with the state they belong to; vectorValid comes one cycle after ST_LOAD_IPL
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      busy_r <= 1'b0;
      suspend_r <= 1'b0;
      info_r <= 1'b0;
      pushValid_r <= 1'b0;
      pushData_r <= 16'h0000;
      vecValid_r <= 1'b0;
      vecNum_r <= 6'h00;
    end
    else
    begin
      busy_r <= state_nxt != ST_IDLE;
      suspend_r <= take && !instrDone;
      info_r <= state_nxt == ST_INFO;
      pushValid_r <= (state_nxt == ST_PUSH_FLG) || (state_nxt == ST_PUSH_PC);
      pushData_r <= (state_nxt == ST_PUSH_FLG) ? {pcSave_r[19:16], 4'h0, tmpFlg_r}
                                               : pcSave_r[15:0];
      vecValid_r <= state_r == ST_LOAD_IPL;
      if (state_r == ST_LOAD_IPL)
        vecNum_r <= accNum_r;
    end
  end

  // ==========================================================
  // wishbone answer, one cycle after the request
  wire logic [31:0] rdMux =
    hitFlg ? {24'h000000, flg_r} :
    hitIpl ? {29'h00000000, ipl_r} :
    hitStat ? {16'h0000, 2'h0, accNum_r, 1'b0, state_r, 1'b0, selValid, wdtPend_r, busy_r} :
    hitCtrl ? {28'h0000000, reqVec[ctrlIdx], lvlVec[ctrlIdx]} :
    32'h00000000;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      ack_r <= 1'b0;
      rdData_r <= 32'h00000000;
    end
    else
    begin
      ack_r <= busReq;
      if (busReq)
        rdData_r <= rdMux;
    end
  end

  assign wbRsp.ack = ack_r;
  assign wbRsp.dat = rdData_r;
  assign seqBusy = busy_r;
  assign suspendReq = suspend_r;
  assign infoRead = info_r;
  assign infoAddr = `IRQ_INFO_ADDR;
  assign stackPush.valid = pushValid_r;
  assign stackPush.data = pushData_r;
  assign vectorValid = vecValid_r;
  assign vectorNum = vecNum_r;
  assign procPriorityLevel = ipl_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence seqSteps;
    state_r == ST_INFO ##1 state_r == ST_SAVE ##1 state_r == ST_CLEAR
    ##1 state_r == ST_PUSH_FLG ##1 state_r == ST_PUSH_PC ##1 state_r == ST_LOAD_IPL;
  endsequence

  sequence pushPair;
    stackPush.valid && stackPush.data[7:0] == tmpFlg_r ##1 stackPush.valid
    && stackPush.data == pcSave_r[15:0];
  endsequence

  seq_order_a: assert property ((state_r == ST_IDLE && take) |=> seqSteps ##1 vectorValid)
    else $error("interrupt sequence steps out of order");
  accept_gate_a: assert property (takeMask |-> flg_r[`IRQ_FLG_I_BIT] && reqVec[selIdx]
    && (lvlVec[selIdx] > ipl_r))
    else $error("maskable taken without its conditions");
  ipl_block_a: assert property ((ipl_r == `IRQ_IPL_MAX) |-> !takeMask)
    else $error("maskable taken with ipl at seven");
  req_set_a: assert property ((srcPulse != '0)
    |=> ((reqVec & $past(srcPulse)) == $past(srcPulse)))
    else $error("source event did not set pending");
  req_clear_a: assert property ((clrPulse && !srcPulse[accIdx_r]) |=> !reqVec[accIdx_r])
    else $error("pending not cleared after info read");
  flag_clear_a: assert property ((state_r == ST_CLEAR) |=> !flg_r[`IRQ_FLG_I_BIT]
    && !flg_r[`IRQ_FLG_D_BIT] && (flg_r[`IRQ_FLG_U_BIT] == ($past(keepU)
    && $past(flg_r[`IRQ_FLG_U_BIT]))))
    else $error("flags not cleared in sequence");
  push_order_a: assert property ((state_r == ST_CLEAR) |=> pushPair)
    else $error("flag and pc pushes wrong");
  ipl_load_a: assert property ((state_r == ST_LOAD_IPL && kind_r == KIND_MASK)
    |=> ipl_r == $past(accLvl_r) && vectorNum == $past(accNum_r))
    else $error("ipl not loaded with accepted level");
  bus_ack_a: assert property (busReq |=> ack_r ##1 !ack_r)
    else $error("wishbone ack not one cycle");

endmodule : maskable_interrupt_acceptance

// *** testbench/cpu_side_model.sv ***
// Purpose: cpu pipeline stand-in: instruction ends, string ops, soft int, pc
// Assumes: one clock, synchronous active-low reset
// Notes: instruction ends every fourth cycle unless a string op runs
`timescale 1ns/1ps

module cpu_side_model #(
  parameter logic [19:0] PC_VAL = 20'h5a3c7
)
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // bench control
  input wire logic stringMode,
  input wire logic swReq,
  input wire logic [5:0] swNum,
  // cpu state
  output logic instrDone,
  output logic stringActive,
  output logic swIntReq,
  output logic [5:0] swIntNum,
  output logic [19:0] pcIn
);
  logic [1:0] phase_r;

  always_ff @(posedge clk)
  begin
    if (!resetn)
      phase_r <= 2'h0;
    else
      phase_r <= phase_r + 2'h1;
  end

  assign instrDone = (phase_r == 2'h3) && !stringMode;
  assign stringActive = stringMode;
  assign swIntReq = swReq && instrDone;
  // number not qualified: show the inverse, not a stale value
  assign swIntNum = swIntReq ? swNum : ~swNum;
  assign pcIn = PC_VAL;
endmodule : cpu_side_model

// *** testbench/maskable_interrupt_acceptance_bench.sv ***
// Purpose: self-checking bench of the interrupt acceptance block
// Assumes: wishbone ack one cycle after a request
// Notes: scenarios run in sequence and build on the ipl left behind
`timescale 1ns/1ps
`include "irq_params.svh"

module maskable_interrupt_acceptance_bench;
  import irq_pkg::*;
  localparam logic [5:0] VB = 6'h08;
  localparam logic [5:0] WV = 6'h3e;
  logic clk, resetn, wdtReq, stringMode, swReq;
  logic instrDone, stringActive, swIntReq, seqBusy, suspendReq, infoRead;
  logic vectorValid, suspSeen;
  logic [5:0] swNum, swIntNum, vectorNum;
  logic [7:0] srcPulse;
  logic [19:0] pcIn, infoAddr, infoSeen;
  logic [2:0] procPriorityLevel;
  logic [31:0] rd;
  wb_req_type wbReq;
  wb_rsp_type wbRsp;
  stack_push_type stackPush;
  logic [15:0] pushes[$];
  int fails, samplesChecked, cycles;

  maskable_interrupt_acceptance #(.NUM_SRC(8), .VEC_BASE(VB), .WDT_VEC(WV))
  i_maskable_interrupt_acceptance (.clk(clk), .resetn(resetn), .wbReq(wbReq),
    .wbRsp(wbRsp), .srcPulse(srcPulse), .wdtReq(wdtReq), .instrDone(instrDone),
    .stringActive(stringActive), .swIntReq(swIntReq), .swIntNum(swIntNum),
    .pcIn(pcIn), .seqBusy(seqBusy), .suspendReq(suspendReq),
    .infoRead(infoRead), .infoAddr(infoAddr), .stackPush(stackPush),
    .vectorValid(vectorValid), .vectorNum(vectorNum),
    .procPriorityLevel(procPriorityLevel));

  cpu_side_model i_cpu_side_model (.clk(clk), .resetn(resetn),
    .stringMode(stringMode), .swReq(swReq), .swNum(swNum),
    .instrDone(instrDone), .stringActive(stringActive), .swIntReq(swIntReq),
    .swIntNum(swIntNum), .pcIn(pcIn));

  // ==========================================================
  // reporting
  task automatic testDone();
    $display("checked %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : testDone

  task automatic check(input string what, input logic [31:0] seen, exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // ==========================================================
  // stimulus helpers
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'h1, dat: d};
    do
      @(posedge clk);
    while (wbRsp.ack !== 1'b1);
    rd = wbRsp.dat;
    wbReq <= '0;
    @(posedge clk);
  endtask : bus

  function automatic logic [7:0] ctl(input logic [2:0] i);
    return `IRQ_CTRL_BASE + {3'h0, i, 2'h0};
  endfunction : ctl

  task automatic pulse(input logic [7:0] m, input logic w);
    srcPulse <= m;
    wdtReq <= w;
    @(posedge clk);
    srcPulse <= '0;
    wdtReq <= 1'b0;
  endtask : pulse

  task automatic waitVec();
    int n;
    n = 0;
    while (vectorValid !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    check("vector", {31'h0, vectorValid}, 32'h1);
    @(posedge clk);
  endtask : waitVec

  // ==========================================================
  // scenarios
  task automatic tMasked();
    bus(1, `IRQ_FLG_OFS, 0);
    check("flags", rd, 0);
    bus(0, `IRQ_FLG_OFS, 0);
    check("flags", rd, 0);
    check("ipl", procPriorityLevel, 0);
    bus(1, ctl(2), 5);
    pulse(8'h04, 0);
    repeat (12) @(posedge clk);
    check("busy", seqBusy, 0);
    bus(0, ctl(2), 0);
    check("ctl2", rd, 32'hd);
    bus(1, ctl(2), 5);
    bus(0, ctl(2), 0);
    check("ctl2", rd, 32'h5);
  endtask : tMasked

  task automatic tAccept();
    pulse(8'h04, 0);
    pushes.delete();
    bus(1, `IRQ_FLG_OFS, 7);
    waitVec();
    check("info", infoSeen, `IRQ_INFO_ADDR);
    check("vnum", vectorNum, VB + 6'h2);
    check("ipl", procPriorityLevel, 5);
    check("push0", pushes[0], 16'h5007);
    check("push1", pushes[1], 16'ha3c7);
    bus(0, `IRQ_FLG_OFS, 0);
    check("flags", rd, 0);
    bus(0, ctl(2), 0);
    check("ctl2", rd, 5);
  endtask : tAccept

  task automatic tIpl();
    bus(1, ctl(3), 5);
    bus(1, `IRQ_FLG_OFS, 1);
    pulse(8'h08, 0);
    repeat (12) @(posedge clk);
    check("busy", seqBusy, 0);
    bus(1, ctl(3), 32'he);
    waitVec();
    check("vnum", vectorNum, VB + 6'h3);
    bus(1, ctl(4), 7);
    bus(1, `IRQ_IPL_OFS, 7);
    bus(1, `IRQ_FLG_OFS, 1);
    pulse(8'h10, 0);
    repeat (12) @(posedge clk);
    check("busy", seqBusy, 0);
    bus(1, `IRQ_IPL_OFS, 6);
    waitVec();
    check("ipl", procPriorityLevel, 7);
  endtask : tIpl

  task automatic tTie();
    bus(1, ctl(1), 4);
    bus(1, ctl(6), 4);
    bus(1, `IRQ_IPL_OFS, 0);
    pulse(8'h42, 0);
    bus(1, `IRQ_FLG_OFS, 1);
    waitVec();
    check("vnum", vectorNum, VB + 6'h1);
    bus(1, `IRQ_IPL_OFS, 0);
    bus(1, `IRQ_FLG_OFS, 1);
    waitVec();
    check("vnum", vectorNum, VB + 6'h6);
  endtask : tTie

  task automatic tOthers();
    pulse(8'h00, 1);
    waitVec();
    check("vnum", vectorNum, WV);
    check("ipl", procPriorityLevel, 7);
    bus(1, ctl(5), 3);
    bus(0, ctl(5), 0);
    check("ctl5", rd, 3);
    bus(1, `IRQ_IPL_OFS, 0);
    bus(1, `IRQ_FLG_OFS, 1);
    stringMode <= 1'b1;
    pulse(8'h20, 0);
    waitVec();
    check("susp", suspSeen, 1);
    stringMode <= 1'b0;
    bus(1, `IRQ_FLG_OFS, 7);
    swNum <= 6'h25;
    swReq <= 1'b1;
    repeat (4) @(posedge clk);
    swReq <= 1'b0;
    waitVec();
    bus(0, `IRQ_FLG_OFS, 0);
    check("flags", rd, 4);
    check("ipl", procPriorityLevel, 3);
  endtask : tOthers

  // ==========================================================
  // clock, monitor, timeout, main
  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (stackPush.valid === 1'b1)
      pushes.push_back(stackPush.data);
    if (infoRead === 1'b1)
      infoSeen = infoAddr;
    if (suspendReq === 1'b1)
      suspSeen = 1;
    if (cycles == 20000)
    begin
      fails++;
      testDone();
    end
  end

  initial
  begin
    {resetn, wdtReq, stringMode, swReq, suspSeen} = '0;
    {swNum, infoSeen} = '1;
    wbReq = '0;
    srcPulse = '0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    tMasked();
    tAccept();
    tIpl();
    tTie();
    tOthers();
    testDone();
  end
endmodule : maskable_interrupt_acceptance_bench
